// >>> rtl/rfs_map.vh
`ifndef RFS_MAP_VH
`define RFS_MAP_VH
// ==========================================================
// register offsets (byte addresses, one 32-bit word each)
`define RFS_OFS_CTRL 4'h0
`define RFS_OFS_FLAG 4'h4
`define RFS_OFS_STAT 4'h8
`define RFS_OFS_MASK 4'hc
// ==========================================================
// control register fields
`define RFS_CTL_EN_LSB 0
`define RFS_CTL_DIS_LSB 4
`define RFS_CTL_PINSEL 8
`define RFS_CTL_OD_LSB 9
`define RFS_CTL_LVL_LSB 11
`define RFS_CTL_SEQ_LSB 13
`define RFS_CTL_SWRST 15
// ==========================================================
// flag register fields (write one to clear)
`define RFS_FLG_SHORT_LSB 0
`define RFS_FLG_OVP 4
`define RFS_FLG_TSD 5
`define RFS_FLG_RST 6
// ==========================================================
// status register fields
`define RFS_STA_RUN_LSB 0
`define RFS_STA_OVP 4
`define RFS_STA_TSD 5
`define RFS_STA_MODE_LSB 6
`define RFS_STA_CLK 8
`define RFS_STA_SUM_LSB 9
// ==========================================================
// reset values
`define RFS_CTL_RST 16'h00f0
`define RFS_MASK_RST 7'h00
// ==========================================================
// timing, figures in ns, clock in MHz
`define RFS_CLK_MHZ 10
`define RFS_T_OVP_RISE_NS 1000
`define RFS_T_OVP_FALL_NS 20000
`define RFS_T_TSD_NS 20000
`define RFS_T_QUAL_NS 1000000
// least times round up to whole cycles
`define RFS_CYC(ns) (((ns) * `RFS_CLK_MHZ + 999) / 1000)
`endif

// >>> rtl/rfs_filt.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// debounce filter: output follows input only after it has
// held the new level for the given number of clocks
module rfs_filt #(
    parameter W = 16,
    parameter RISE_CYC = 10,
    parameter FALL_CYC = 10
) (
    input wire clk_sys, // system clock
    input wire rst, // sync reset, high
    input wire ce, // clock enable
    input wire din, // synchronised level
    output reg dout // filtered level
);
    reg [W-1:0] cnt_r; // cycles the input has differed
    wire [W-1:0] lim; // window for the pending edge

    assign lim = dout ? FALL_CYC[W-1:0] : RISE_CYC[W-1:0];

    // ======================================================
    // window counter, restarts whenever input agrees again
    always @(posedge clk_sys) begin
        if (rst) begin
            cnt_r <= {W{1'b0}};
            dout <= 1'b0;
        end else if (ce) begin
            if (din == dout) begin
                cnt_r <= {W{1'b0}};
            end else if (cnt_r + 1'b1 >= lim) begin
                // accurate to one clock period
                cnt_r <= {W{1'b0}};
                dout <= din;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule // rfs_filt
`default_nettype wire

// >>> rtl/rfs_top.v
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rfs_map.vh"
module rfs_top #(
    parameter [15:0] OTP_CTRL = `RFS_CTL_RST, // nonvolatile ctrl
    parameter [6:0] OTP_MASK = `RFS_MASK_RST, // nonvolatile mask
    parameter QUAL_CYC = `RFS_CYC(`RFS_T_QUAL_NS) // 1 ms window
) (
    input wire clk_sys, // system clock, 10 MHz
    input wire rst, // sync reset, high
    input wire ce, // clock enable, freezes all state
    input wire [3:0] avs_address, // byte address
    input wire avs_read, // read request
    input wire avs_write, // write request
    input wire [31:0] avs_writedata, // write data
    output reg [31:0] avs_readdata, // read data
    output wire avs_waitrequest, // stall
    input wire en_pin, // enable pin, async
    input wire supply_ok, // analog supply above uvlo, async
    input wire ovp_raw, // input overvoltage comparator, async
    input wire hot_raw, // die over temperature, async
    input wire [3:0] out_low, // output under short threshold
    output wire [3:0] stage_on, // power stage enable
    output wire [3:0] stage_hiz, // power stage high-z
    output wire [3:0] discharge_on, // pulldown resistor on
    output reg interrupt_request_n, // interrupt, low active
    output reg first_general_output, // pin out
    output reg first_general_output_oe_n, // pin enable, low
    input wire shared_pin_in, // shared pin level, async
    output reg second_general_output, // shared pin out
    output reg second_general_output_oe_n, // shared pin enable
    output wire [1:0] mode // 0 off,1 otp,2 standby,3 active
);
    // ======================================================
    // modes
    localparam [1:0] M_OFF = 2'h0; // shutdown
    localparam [1:0] M_OTP = 2'h1; // read nonvolatile
    localparam [1:0] M_STBY = 2'h2; // standby
    localparam [1:0] M_ACT = 2'h3; // active
    localparam QW = 16; // qualification counter width
    localparam [QW-1:0] QLIM = QUAL_CYC[QW-1:0];

    // ======================================================
    // registers and state
    reg [1:0] mode_r; // current mode
    reg [1:0] mode_nxt; // next mode
    reg [15:0] ctrl_r; // control register
    reg [6:0] mask_r; // interrupt mask
    reg [6:0] flag_r; // latched flags
    reg [6:0] flag_nxt; // next flags
    reg [3:0] run_r; // regulator running
    reg [3:0] run_nxt; // next running
    reg ack_r; // bus answer cycle
    reg [1:0] en_s_r, sup_s_r, ovp_s_r, hot_s_r, pin_s_r; // syncs
    reg [3:0] low_s1_r, low_s2_r; // comparator syncs
    wire input_overvoltage_status; // filtered overvoltage
    wire hot_stat; // filtered over temperature
    wire [3:0] fault; // short or overload pulse
    wire [3:0] sw_en; // software enables
    wire [3:0] dis_en; // discharge enables
    wire block; // enables refused
    wire sw_rst; // software reset write
    wire wr_hit; // bus write taken
    wire [6:0] w1c; // flags cleared by this write
    wire clk_sample; // sampled sync clock level

    // ======================================================
    // helpers
    function [31:0] rd_mux;
        input [3:0] a;
        input [15:0] c;
        input [6:0] f;
        input [31:0] s;
        input [6:0] m;
        begin
            case (a)
                `RFS_OFS_CTRL: rd_mux = {16'h0000, c};
                `RFS_OFS_FLAG: rd_mux = {25'h0000000, f};
                `RFS_OFS_STAT: rd_mux = s;
                `RFS_OFS_MASK: rd_mux = {25'h0000000, m};
                default: rd_mux = 32'h00000000; // unmapped reads 0
            endcase
        end
    endfunction

    // ======================================================
    // two-flop synchronisers for every outside level
    always @(posedge clk_sys) begin
        if (rst) begin
            en_s_r <= 2'h0;
            sup_s_r <= 2'h0;
            ovp_s_r <= 2'h0;
            hot_s_r <= 2'h0;
            pin_s_r <= 2'h0;
            low_s1_r <= 4'h0;
            low_s2_r <= 4'h0;
        end else if (ce) begin
            // enable and uvlo rise: synchroniser only
            en_s_r <= {en_s_r[0], en_pin};
            sup_s_r <= {sup_s_r[0], supply_ok};
            ovp_s_r <= {ovp_s_r[0], ovp_raw};
            hot_s_r <= {hot_s_r[0], hot_raw};
            pin_s_r <= {pin_s_r[0], shared_pin_in};
            low_s1_r <= out_low;
            low_s2_r <= low_s1_r;
        end
    end
    assign clk_sample = pin_s_r[1];

    // ======================================================
    // overvoltage and thermal debounce
    rfs_filt #(
        .W(8),
        .RISE_CYC(`RFS_CYC(`RFS_T_OVP_RISE_NS)),
        .FALL_CYC(`RFS_CYC(`RFS_T_OVP_FALL_NS))
    ) u_ovp (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .din(ovp_s_r[1]),
        .dout(input_overvoltage_status)
    );
    rfs_filt #(
        .W(8),
        .RISE_CYC(`RFS_CYC(`RFS_T_TSD_NS)),
        .FALL_CYC(`RFS_CYC(`RFS_T_TSD_NS))
    ) u_hot (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .din(hot_s_r[1]),
        .dout(hot_stat)
    );

    // ======================================================
    // per regulator: start-up qualification then overload
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_reg
            reg [QW-1:0] st_r; // cycles since enable
            reg qual_r; // start-up window over
            wire ovl; // low for the whole window
            // start-up timer restarts on every fresh enable
            always @(posedge clk_sys) begin
                if (rst) begin
                    st_r <= {QW{1'b0}};
                    qual_r <= 1'b0;
                end else if (ce) begin
                    if (!run_r[gi]) begin
                        st_r <= {QW{1'b0}};
                        qual_r <= 1'b0;
                    end else if (!qual_r) begin
                        if (st_r + 1'b1 >= QLIM) begin
                            qual_r <= 1'b1;
                        end
                        st_r <= st_r + 1'b1;
                    end
                end
            end
            // overload only counted once start-up passed
            rfs_filt #(
                .W(QW),
                .RISE_CYC(QUAL_CYC),
                .FALL_CYC(1)
            ) u_ovl (
                .clk_sys(clk_sys),
                .rst(rst),
                .ce(ce),
                .din(low_s2_r[gi] & qual_r & run_r[gi]),
                .dout(ovl)
            );
            // short at window end, or sustained overload
            assign fault[gi] = run_r[gi] & (
                (!qual_r && st_r + 1'b1 >= QLIM
                 && low_s2_r[gi])
                | (ovl & qual_r));
        end
    endgenerate

    // ======================================================
    // bus slave: one wait cycle, answer in the next
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_hit = avs_write & ack_r & ce;
    assign w1c = (wr_hit && avs_address == `RFS_OFS_FLAG)
        ? avs_writedata[6:0] : 7'h00;
    assign sw_rst = wr_hit && avs_address == `RFS_OFS_CTRL
        && avs_writedata[`RFS_CTL_SWRST];

    always @(posedge clk_sys) begin
        if (rst) begin
            ack_r <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else if (ce) begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
            if (avs_read && !ack_r) begin
                avs_readdata <= rd_mux(avs_address, ctrl_r, flag_r,
                    {19'h00000, flag_r[3:0], clk_sample, mode_r,
                     hot_stat, input_overvoltage_status, run_r}, mask_r);
            end
        end
    end

    // ======================================================
    // enable gating and fault response
    assign sw_en = ctrl_r[`RFS_CTL_EN_LSB +: 4];
    assign dis_en = ctrl_r[`RFS_CTL_DIS_LSB +: 4];
    // refused while either condition is live or pending
    assign block = input_overvoltage_status | flag_r[`RFS_FLG_OVP]
        | hot_stat | flag_r[`RFS_FLG_TSD];

    always @* begin
        run_nxt = 4'h0;
        if (mode_r == M_STBY || mode_r == M_ACT) begin
            // fault flag pending keeps it off; clearing retries
            run_nxt = sw_en & ~flag_r[3:0] & ~fault;
            // lockout or soft reset drops stages on the same edge
            if (block || !sup_s_r[1] || sw_rst) begin
                run_nxt = 4'h0;
            end
        end
    end

    // ======================================================
    // flags: hardware set wins over a write-one clear
    always @* begin
        flag_nxt = flag_r & ~w1c;
        flag_nxt[3:0] = flag_nxt[3:0] | fault;
        // live level re-sets, so a clear while high is lost
        if (input_overvoltage_status) begin
            flag_nxt[`RFS_FLG_OVP] = 1'b1;
        end
        if (hot_stat) begin
            flag_nxt[`RFS_FLG_TSD] = 1'b1;
        end
    end

    // ======================================================
    // mode machine
    always @* begin
        case (mode_r)
            M_OFF: mode_nxt = M_OTP;
            M_OTP: mode_nxt = M_STBY;
            M_STBY: mode_nxt = |run_r ? M_ACT : M_STBY;
            M_ACT: mode_nxt = |run_r ? M_ACT : M_STBY;
            default: mode_nxt = M_OFF;
        endcase
        if (!sup_s_r[1] || sw_rst) begin
            mode_nxt = M_OFF;
        end
    end

    // ======================================================
    // state and register update
    always @(posedge clk_sys) begin
        if (rst) begin
            mode_r <= M_OFF;
            ctrl_r <= `RFS_CTL_RST;
            mask_r <= `RFS_MASK_RST;
            flag_r <= 7'h00;
            run_r <= 4'h0;
        end else if (ce) begin
            mode_r <= mode_nxt;
            run_r <= run_nxt;
            flag_r <= flag_nxt;
            if (mode_r == M_OFF) begin
                // all off; registers back to defaults
                run_r <= 4'h0;
                ctrl_r <= `RFS_CTL_RST;
                mask_r <= `RFS_MASK_RST;
                flag_r <= 7'h00;
            end else if (mode_r == M_OTP) begin
                // regulators stay off while loading
                run_r <= 4'h0;
                ctrl_r <= OTP_CTRL;
                mask_r <= OTP_MASK;
                // reset flag only when unmasked
                flag_r[`RFS_FLG_RST] <= ~OTP_MASK[`RFS_FLG_RST];
            end else if (wr_hit && !sw_rst) begin
                if (avs_address == `RFS_OFS_CTRL) begin
                    ctrl_r <= avs_writedata[15:0];
                    ctrl_r[`RFS_CTL_SWRST] <= 1'b0;
                end
                if (avs_address == `RFS_OFS_MASK) begin
                    mask_r <= avs_writedata[6:0];
                end
            end
        end
    end

    // ======================================================
    // interrupt: low while any unmasked flag is set
    always @(posedge clk_sys) begin
        if (rst) begin
            interrupt_request_n <= 1'b1;
        end else if (ce) begin
            interrupt_request_n <= ~|(flag_r & ~mask_r);
        end
    end

    // ======================================================
    // power stages: off means high-z, pulldown if enabled
    assign stage_on = run_r;
    assign stage_hiz = ~run_r;
    assign discharge_on = ~run_r & dis_en;
    assign mode = mode_r;

    // ======================================================
    // general outputs
    // limitation: overvoltage holds both outputs low (the second
    // only when it is not the sync clock input) until its flag is
    // cleared, whatever the level bits say
    always @(posedge clk_sys) begin : p_gpo
        reg [1:0] lvl;
        reg [1:0] od;
        lvl = 2'h0;
        od = 2'h0;
        if (rst) begin
            first_general_output <= 1'b0;
            first_general_output_oe_n <= 1'b1;
            second_general_output <= 1'b0;
            second_general_output_oe_n <= 1'b1;
        end else if (ce) begin
            od = ctrl_r[`RFS_CTL_OD_LSB +: 2];
            lvl = ctrl_r[`RFS_CTL_LVL_LSB +: 2];
            // follow the enable pin sequence instead
            lvl = lvl & ~ctrl_r[`RFS_CTL_SEQ_LSB +: 2]
                | ({2{en_s_r[1]}} & lvl
                   & ctrl_r[`RFS_CTL_SEQ_LSB +: 2]);
            if (flag_r[`RFS_FLG_OVP] || input_overvoltage_status
                || mode_r == M_OFF || mode_r == M_OTP) begin
                lvl = 2'h0;
            end
            // open drain pulls low only; push-pull drives both
            first_general_output <= od[0] ? 1'b0 : lvl[0];
            first_general_output_oe_n <= od[0] ? lvl[0] : 1'b0;
            if (ctrl_r[`RFS_CTL_PINSEL]) begin
                // pin is the sync clock input, never driven
                second_general_output <= 1'b0;
                second_general_output_oe_n <= 1'b1;
            end else begin
                second_general_output <= od[1] ? 1'b0 : lvl[1];
                second_general_output_oe_n <= od[1] ? lvl[1] : 1'b0;
            end
        end
    end
endmodule // rfs_top
`default_nettype wire

// >>> bench/rfs_plant.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// regulator output model: low while off, ramps up in a few
// clocks after the stage starts, or held low by a forced short
module rfs_plant (
    input wire logic clk_sys, // system clock
    input wire logic [3:0] stage_on, // power stage running
    input wire logic [3:0] short_cmd, // forced short per stage
    output logic [3:0] out_low // output under threshold
);
    logic [1:0] ramp_r [0:3]; // rise progress per stage
    integer i;
    // ramp kept short so a clean start never trips the window
    initial begin
        for (i = 0; i < 4; i = i + 1) ramp_r[i] = 2'h0;
    end
    // private loop indices, so the two processes share no loop variable
    always @(posedge clk_sys) begin
        for (int j = 0; j < 4; j = j + 1) begin
            if (!stage_on[j]) ramp_r[j] <= 2'h0;
            else if (ramp_r[j] != 2'h3) ramp_r[j] <= ramp_r[j] + 2'h1;
        end
    end
    always @* begin
        for (int m = 0; m < 4; m = m + 1)
            out_low[m] = short_cmd[m] || (ramp_r[m] != 2'h3);
    end
endmodule // rfs_plant
`default_nettype wire

// >>> bench/rfs_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker for the supervisor top
module rfs_chk #(
    parameter QUAL_CYC = 20 // fault window in clocks
) (
    input wire clk_sys, // system clock
    input wire rst, // sync reset, high
    input wire avs_read, // read request
    input wire avs_write, // write request
    input wire avs_waitrequest, // stall
    input wire ovp_raw, // overvoltage comparator
    input wire hot_raw, // over temperature
    input wire supply_ok, // supply above lockout
    input wire [3:0] out_low, // output under threshold
    input wire [3:0] stage_on, // stage running
    input wire [3:0] stage_hiz, // stage high-z
    input wire [3:0] discharge_on, // pulldown on
    input wire interrupt_request_n, // interrupt, low
    input wire [1:0] mode // operating mode
);
    logic [15:0] low_r; // cycles any stage runs while low
    logic [8:0] hot_r; // consecutive hot cycles, saturating
    // ==========================================================
    // helper counters
    always @(posedge clk_sys) begin
        if (rst) begin
            low_r <= 16'h0;
            hot_r <= 9'h0;
        end else begin
            low_r <= |(stage_on & out_low) ? low_r + 16'h1 : 16'h0;
            if (!hot_raw) hot_r <= 9'h0;
            else if (hot_r != 9'h1ff) hot_r <= hot_r + 9'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence ovp_held;
        ovp_raw [*8] ##1 ovp_raw [*8];
    endsequence
    sequence uv_held;
        !supply_ok [*6];
    endsequence
    sequence bus_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    // ==========================================================
    // assertions
    hiz_inverse_a: assert property (stage_hiz == ~stage_on)
        else $error("stage high-z not inverse of stage on");
    discharge_off_a: assert property ((discharge_on & stage_on) == 4'h0)
        else $error("pulldown on while stage runs");
    short_limit_a: assert property (low_r <= QUAL_CYC + 6)
        else $error("stage kept running while output low");
    ovp_off_a: assert property (ovp_held |-> stage_on == 4'h0
        && interrupt_request_n == 1'b0)
        else $error("overvoltage left stage on or irq high");
    ovp_block_a: assert property (ovp_held ##1 ovp_raw |-> $stable(stage_on))
        else $error("stage changed during overvoltage");
    hot_off_a: assert property (hot_r > 9'd210 |-> stage_on == 4'h0
        && mode != 2'h3)
        else $error("stage on or active while hot");
    uv_off_a: assert property (uv_held |-> mode == 2'h0 && stage_on == 4'h0)
        else $error("lockout did not shut down");
    active_mode_a: assert property (stage_on != 4'h0 ##1 stage_on != 4'h0
        |-> mode == 2'h3)
        else $error("stage running outside active mode");
    bus_answer_a: assert property (bus_wait |=> !avs_waitrequest)
        else $error("bus answer later than one wait cycle");
    bus_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without request");
endmodule // rfs_chk
`default_nettype wire

// >>> bench/test_rfs_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench for the supervisor top
module test_rfs_top;
    localparam QUAL = 20; // shortened fault window
    localparam [15:0] DEF = 16'h00f0; // control default
    logic clk_sys = 1'b0; // system clock
    logic rst = 1'b1; // sync reset
    logic [3:0] avs_address = 4'h0; // bus address
    logic avs_read = 1'b0; // read strobe
    logic avs_write = 1'b0; // write strobe
    logic [31:0] avs_writedata = 32'h0; // write data
    wire [31:0] avs_readdata; // read data
    wire avs_waitrequest; // stall
    logic en_pin = 1'b0; // enable pin
    logic supply_ok = 1'b1; // supply good
    logic ovp_raw = 1'b0; // overvoltage
    logic hot_raw = 1'b0; // over temperature
    logic shared_pin_in = 1'b0; // shared pin level
    logic [3:0] short_cmd = 4'h0; // plant short request
    wire [3:0] out_low, stage_on, stage_hiz, discharge_on;
    wire irq_n, o1, o1_oe_n, o2, o2_oe_n;
    wire [1:0] mode;
    integer fails = 0, compares = 0, cyc_n = 0, seed = 32'he832, k;
    logic [31:0] rq; // last read word
    logic [1:0] lv; // random output levels
    logic [15:0] cv; // control value sent
    always #50 clk_sys = ~clk_sys;
    rfs_top #(.QUAL_CYC(QUAL)) u_rfs_top (.clk_sys(clk_sys), .rst(rst),
        .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .en_pin(en_pin), .supply_ok(supply_ok), .ovp_raw(ovp_raw),
        .hot_raw(hot_raw), .out_low(out_low), .stage_on(stage_on),
        .stage_hiz(stage_hiz), .discharge_on(discharge_on),
        .interrupt_request_n(irq_n), .first_general_output(o1),
        .first_general_output_oe_n(o1_oe_n), .shared_pin_in(shared_pin_in),
        .second_general_output(o2), .second_general_output_oe_n(o2_oe_n),
        .mode(mode));
    rfs_plant u_rfs_plant (.clk_sys(clk_sys), .stage_on(stage_on),
        .short_cmd(short_cmd), .out_low(out_low));
    // ==========================================================
    // helpers
    task end_sim;
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    // one request held until the edge that sees waitrequest low
    task bus(input wr, input [3:0] a, input [31:0] d);
        integer n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && n < 100) begin
            @(posedge clk_sys);
            n = n + 1;
        end
        if (n >= 100) fails = fails + 1;
        rq = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // wait for standby, then defaults and reset flag
    task boot;
        integer n;
        n = 0;
        while (mode !== 2'h2 && n < 200) begin
            cyc(1);
            n = n + 1;
        end
        if (n >= 200) fails = fails + 1;
        bus(0, 4'h0, 0);
        chk("ctrl", rq, {16'h0, DEF});
        bus(0, 4'h4, 0);
        chk("flag", rq, 32'h40);
        chk("irq", irq_n, 1'b0);
        bus(1, 4'h4, 32'h40);
        bus(0, 4'h4, 0);
        chk("flag", rq, 32'h0);
        chk("irq", irq_n, 1'b1);
    endtask
    always @(posedge clk_sys) begin
        cyc_n = cyc_n + 1;
        if (cyc_n == 30000) begin
            fails = fails + 1;
            end_sim;
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        cyc(5);
        rst <= 1'b0;
        boot;
        bus(1, 4'h1, 32'hffff);
        bus(0, 4'h1, 0);
        chk("unmapped", rq, 32'h0);
        bus(0, 4'hc, 0);
        chk("mask", rq, 32'h0);
        for (k = 0; k < 4; k = k + 1) begin
            lv = $random(seed);
            bus(1, 4'h0, DEF | (k << 9) | (lv << 11));
            cyc(3);
            chk("out1", {o1, o1_oe_n}, k[0] ? {1'b0, lv[0]} : {lv[0], 1'b0});
            chk("out2", {o2, o2_oe_n}, k[1] ? {1'b0, lv[1]} : {lv[1], 1'b0});
        end
        bus(1, 4'h0, DEF | 16'h2800);
        cyc(5);
        chk("follow", o1, 1'b0);
        en_pin <= 1'b1;
        cyc(6);
        chk("follow", o1, 1'b1);
        bus(1, 4'h0, DEF | 16'h0100);
        for (k = 0; k < 4; k = k + 1) begin
            lv = $random(seed);
            shared_pin_in <= lv[0];
            cyc(5);
            bus(0, 4'h8, 0);
            chk("pin", {rq[8], o2_oe_n}, {lv[0], 1'b1});
        end
        short_cmd <= 4'h2;
        bus(1, 4'h0, DEF | 16'h0003);
        cyc(QUAL + 10);
        chk("stage", {stage_on, discharge_on}, 8'h1e);
        chk("irq", irq_n, 1'b0);
        bus(1, 4'h4, 32'h0);
        bus(0, 4'h4, 0);
        chk("flag", rq, 32'h2);
        bus(0, 4'h8, 0);
        chk("stat", {rq[12:9], rq[7:6], rq[3:0]}, 10'h0b1);
        short_cmd <= 4'h0;
        bus(1, 4'h4, 32'h2);
        cyc(QUAL + 10);
        chk("retry", stage_on, 4'h3);
        chk("irq", irq_n, 1'b1);
        bus(1, 4'h0, DEF | 16'h0807);
        cyc(QUAL + 10);
        short_cmd <= 4'h4;
        cyc(QUAL + 10);
        chk("overload", stage_on, 4'h3);
        bus(0, 4'h4, 0);
        chk("flag", rq, 32'h4);
        short_cmd <= 4'h0;
        ovp_raw <= 1'b1;
        cyc(5);
        ovp_raw <= 1'b0;
        cyc(5);
        chk("ovp glitch", stage_on, 4'h3);
        ovp_raw <= 1'b1;
        cyc(30);
        chk("ovp", {stage_on, o1, o1_oe_n}, 6'h0);
        bus(1, 4'h4, 32'h14);
        bus(0, 4'h4, 0);
        chk("flag", rq, 32'h10);
        bus(0, 4'h8, 0);
        chk("stat", {rq[4], rq[3:0]}, 5'h10);
        ovp_raw <= 1'b0;
        cyc(230);
        bus(0, 4'h8, 0);
        chk("stat", {rq[4], stage_on}, 5'h0);
        bus(1, 4'h4, 32'h10);
        bus(0, 4'h4, 0);
        chk("flag", rq, 32'h0);
        hot_raw <= 1'b1;
        cyc(250);
        chk("hot", {stage_on, mode}, 6'h2);
        bus(1, 4'h4, 32'h20);
        bus(0, 4'h4, 0);
        chk("flag", rq, 32'h20);
        bus(0, 4'h8, 0);
        chk("stat", rq[5], 1'b1);
        hot_raw <= 1'b0;
        cyc(230);
        bus(1, 4'h4, 32'h20);
        bus(0, 4'h4, 0);
        chk("flag", rq, 32'h0);
        bus(1, 4'h0, 32'h0010);
        supply_ok <= 1'b0;
        cyc(10);
        chk("uvlo", {mode, stage_on, discharge_on}, 10'h00f);
        supply_ok <= 1'b1;
        boot;
        bus(1, 4'h0, 32'h8007);
        boot;
        end_sim;
    end
endmodule // test_rfs_top
bind rfs_top rfs_chk #(.QUAL_CYC(QUAL_CYC)) u_rfs_chk (.clk_sys(clk_sys),
    .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .ovp_raw(ovp_raw), .hot_raw(hot_raw),
    .supply_ok(supply_ok), .out_low(out_low), .stage_on(stage_on),
    .stage_hiz(stage_hiz), .discharge_on(discharge_on),
    .interrupt_request_n(interrupt_request_n), .mode(mode));
`default_nettype wire
